// [rtl/cmch_top.sv]
// module: mode control and handshake register block of a CAN controller
//
// Summary of operation
// - control register readable always, written only in initialization mode.
// - enable bit written once normally, freely in special mode during init.
// - enable bit zero disables the controller, one enables it.
// - clock select zero picks oscillator clock, one picks bus clock.
// - loopback feeds transmitter to receiver; transmit pin held recessive.
// - loopback accepts own frame, ignoring acknowledge slot bit.
// - looped-back frame raises both transmit and receive interrupts.
// - listen-only receives matching frames, drives no ack or error frame.
// - listen-only freezes transmit and receive error counters.
// - listen-only never starts a transmission.
// - wake filter zero wakes on any dominant; one needs minimum pulse.
// - sleep ack read-only; sleep active when request and ack both set.
// - wake enabled and bus activity in sleep clears sleep ack.
// - init ack read-only; init active when request and ack both set.
// - control, timing and acceptance registers written only in init mode.
// - sleep entered only when no reception and transmit buffers empty.
// - init request aborts frames; resync after eleven recessive bits.
// - wake enable lets bus traffic end sleep; otherwise ignored.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module cmch_top #(
  parameter int WAKE_CYCLES = cmch_pkg::WAKE_PULSE_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             avs_response_err,
  input  wire logic        special_mode_i,
  input  wire logic        bus_receive_pin_i,
  output logic             bus_transmit_pin_o,
  input  wire logic        core_tx_bit_i,
  input  wire logic        core_tx_busy_i,
  input  wire logic        core_rx_busy_i,
  input  wire logic        core_tx_empty_i,
  input  wire logic        core_tx_done_i,
  input  wire logic        core_rx_done_i,
  input  wire logic        core_bit_tick_i,
  input  wire logic        core_bus_off_i,
  output logic             core_rx_bit_o,
  output logic             core_enable_o,
  output logic             core_clk_sel_o,
  output logic             core_abort_o,
  output logic             core_synced_o,
  output logic             core_ack_ignore_o,
  output logic             core_ack_drive_en_o,
  output logic             core_err_frame_en_o,
  output logic             core_err_cnt_freeze_o,
  output logic             core_tx_start_en_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic rx_meta_q;
  logic rx_sync_q;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= bus_receive_pin_i;
      rx_sync_q <= rx_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic       enable_written_q;
  logic [7:0] btr_a_q;
  logic [7:0] btr_b_q;
  logic [7:0] acc_ctl_q;
  logic [7:0] acc_code_q;
  logic [7:0] acc_mask_q;
  localparam int IRQ_W_L = cmch_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_stat_q;
  logic [IRQ_W_L-1:0] irq_en_q;

  logic init_req;
  logic sleep_req;
  logic wake_en;
  logic init_ack;
  logic sleep_ack;
  logic in_init;
  logic loop_on;
  logic listen_on;
  assign init_req  = ctl0_q[cmch_pkg::CTL0_INIT_REQUEST];
  assign sleep_req = ctl0_q[cmch_pkg::CTL0_SLEEP_REQUEST];
  assign wake_en   = ctl0_q[cmch_pkg::CTL0_WAKE];
  assign init_ack  = ctl1_q[cmch_pkg::CTL1_INIT_ACK_FLAG];
  assign sleep_ack = ctl1_q[cmch_pkg::CTL1_SLEEP_ACK_FLAG];
  assign in_init   = init_req && init_ack;
  assign loop_on   = ctl1_q[cmch_pkg::CTL1_LOOP];
  assign listen_on = ctl1_q[cmch_pkg::CTL1_LISTEN];

  // ---------------------------------------------------------------
  // bus slave: one-cycle wait, answer on second edge
  // ---------------------------------------------------------------
  logic req;
  logic ack_q;
  logic wr_fire;
  logic rd_fire;
  logic mapped;
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign wr_fire         = avs_write && ack_q;
  assign rd_fire         = avs_read && !ack_q;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    mapped = 1'b1;
    case (avs_address)
      cmch_pkg::ADDR_CTL0, cmch_pkg::ADDR_CTL1, cmch_pkg::ADDR_BTR_A,
      cmch_pkg::ADDR_BTR_B, cmch_pkg::ADDR_ACC_CTL,
      cmch_pkg::ADDR_ACC_CODE, cmch_pkg::ADDR_ACC_MASK,
      cmch_pkg::ADDR_IRQ_STAT, cmch_pkg::ADDR_IRQ_CLR,
      cmch_pkg::ADDR_IRQ_EN, cmch_pkg::ADDR_CORE_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  logic [7:0] wd;
  assign wd = avs_writedata[7:0];

  // ---------------------------------------------------------------
  // control register 0: requests and wake enable
  // ---------------------------------------------------------------
  logic wake_hit;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl0_q <= cmch_pkg::CTL0_RESET;
    end else begin
      if (wr_fire && avs_address == cmch_pkg::ADDR_CTL0) begin
        // requests cannot be dropped before their ack arrives
        ctl0_q[cmch_pkg::CTL0_WAKE] <= wd[cmch_pkg::CTL0_WAKE];
        if (wd[cmch_pkg::CTL0_INIT_REQUEST] || in_init) begin
          ctl0_q[cmch_pkg::CTL0_INIT_REQUEST] <= wd[cmch_pkg::CTL0_INIT_REQUEST];
        end
        if (wd[cmch_pkg::CTL0_SLEEP_REQUEST] || (sleep_req && sleep_ack)) begin
          ctl0_q[cmch_pkg::CTL0_SLEEP_REQUEST] <= wd[cmch_pkg::CTL0_SLEEP_REQUEST];
        end
      end
      if (wake_hit) begin
        ctl0_q[cmch_pkg::CTL0_SLEEP_REQUEST] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // mode control handshake register
  // ---------------------------------------------------------------
  logic bus_idle;
  assign bus_idle = !core_rx_busy_i && !core_tx_busy_i && core_tx_empty_i;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl1_q           <= cmch_pkg::CTL1_RESET;
      enable_written_q <= 1'b0;
    end else begin
      if (wr_fire && avs_address == cmch_pkg::ADDR_CTL1 && in_init) begin
        ctl1_q[6:2] <= wd[6:2] & cmch_pkg::CTL1_WR_MASK[6:2];
        if (special_mode_i || !enable_written_q) begin
          ctl1_q[cmch_pkg::CTL1_ENABLE] <= wd[cmch_pkg::CTL1_ENABLE];
          enable_written_q <= 1'b1;
        end
      end
      ctl1_q[cmch_pkg::CTL1_INIT_ACK_FLAG] <= init_req;
      if (wake_hit || !sleep_req) begin
        ctl1_q[cmch_pkg::CTL1_SLEEP_ACK_FLAG] <= 1'b0;
      end else if (bus_idle && !init_req) begin
        ctl1_q[cmch_pkg::CTL1_SLEEP_ACK_FLAG] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // bit-timing and acceptance registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      btr_a_q    <= 8'h00;
      btr_b_q    <= 8'h00;
      acc_ctl_q  <= 8'h00;
      acc_code_q <= 8'h00;
      acc_mask_q <= 8'h00;
    end else if (wr_fire && in_init) begin
      case (avs_address)
        cmch_pkg::ADDR_BTR_A:    btr_a_q    <= wd;
        cmch_pkg::ADDR_BTR_B:    btr_b_q    <= wd;
        cmch_pkg::ADDR_ACC_CTL:  acc_ctl_q  <= wd;
        cmch_pkg::ADDR_ACC_CODE: acc_code_q <= wd;
        cmch_pkg::ADDR_ACC_MASK: acc_mask_q <= wd;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // wake detection
  // ---------------------------------------------------------------
  cmch_core_if cif ();
  logic sleeping;
  assign sleeping      = sleep_req && sleep_ack;
  assign cif.bus_rx    = rx_sync_q;
  assign cif.wake_filt = ctl1_q[cmch_pkg::CTL1_WFILT];
  assign cif.sleeping  = sleeping;

  cmch_wake_filter #(
    .PULSE_CYCLES (WAKE_CYCLES)
  ) u_wake (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .core      (cif.filt)
  );

  assign wake_hit = wake_en && cif.wake_req;

  // ---------------------------------------------------------------
  // resynchronisation after init release
  // ---------------------------------------------------------------
  logic [3:0] recess_cnt_q;
  logic       synced_q;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      recess_cnt_q <= 4'h0;
      synced_q     <= 1'b0;
    end else if (init_req || core_bus_off_i || !rx_sync_q) begin
      recess_cnt_q <= 4'h0;
      synced_q     <= synced_q && !init_req && rx_sync_q;
    end else if (core_bit_tick_i && !synced_q) begin
      if (recess_cnt_q == 4'(cmch_pkg::RESYNC_RECESSIVE - 1)) begin
        synced_q <= 1'b1;
      end
      recess_cnt_q <= recess_cnt_q + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // mode outputs to the frame engine
  // ---------------------------------------------------------------
  // enable gate
  assign core_enable_o  = ctl1_q[cmch_pkg::CTL1_ENABLE];
  assign core_clk_sel_o = ctl1_q[cmch_pkg::CTL1_CLKSEL];
  assign core_abort_o   = init_req;
  assign core_synced_o  = synced_q;
  assign core_rx_bit_o  = loop_on ? core_tx_bit_i : rx_sync_q;
  assign core_ack_ignore_o     = loop_on;
  assign core_ack_drive_en_o   = !listen_on && !loop_on;
  assign core_err_frame_en_o   = !listen_on;
  assign core_err_cnt_freeze_o = listen_on;
  assign core_tx_start_en_o    = !listen_on && core_enable_o && !init_req
                                 && !sleeping;

  logic tx_pin_q;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_pin_q <= 1'b1;
    end else begin
      tx_pin_q <= core_tx_bit_i;
    end
  end
  // recessive forced at once so a request never corrupts a frame
  assign bus_transmit_pin_o = (loop_on || init_req || listen_on ||
                               !core_enable_o) ? 1'b1 : tx_pin_q;

  // ---------------------------------------------------------------
  // interrupts: sticky status, write-one clear, enable mask
  // ---------------------------------------------------------------
  logic [IRQ_W_L-1:0] irq_set;
  logic [IRQ_W_L-1:0] irq_clr;
  always_comb begin
    irq_set = '0;
    irq_set[cmch_pkg::IRQ_TX]   = core_tx_done_i;
    irq_set[cmch_pkg::IRQ_RX]   = core_rx_done_i;
    irq_set[cmch_pkg::IRQ_WAKE] = wake_hit;
    irq_clr = (wr_fire && avs_address == cmch_pkg::ADDR_IRQ_CLR) ?
              wd[IRQ_W_L-1:0] : '0;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat_q <= '0;
    end else begin
      // set wins over a simultaneous clear
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_en_q <= '0;
    end else if (wr_fire && avs_address == cmch_pkg::ADDR_IRQ_EN) begin
      irq_en_q <= wd[IRQ_W_L-1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_readdata     <= 32'h0000_0000;
      avs_response_err <= 1'b0;
    end else if (rd_fire || (avs_write && !ack_q)) begin
      avs_response_err <= !mapped;
      avs_readdata     <= 32'h0000_0000;
      if (avs_read) begin
        case (avs_address)
          cmch_pkg::ADDR_CTL0:     avs_readdata[7:0] <= ctl0_q;
          cmch_pkg::ADDR_CTL1:     avs_readdata[7:0] <= ctl1_q;
          cmch_pkg::ADDR_BTR_A:    avs_readdata[7:0] <= btr_a_q;
          cmch_pkg::ADDR_BTR_B:    avs_readdata[7:0] <= btr_b_q;
          cmch_pkg::ADDR_ACC_CTL:  avs_readdata[7:0] <= acc_ctl_q;
          cmch_pkg::ADDR_ACC_CODE: avs_readdata[7:0] <= acc_code_q;
          cmch_pkg::ADDR_ACC_MASK: avs_readdata[7:0] <= acc_mask_q;
          cmch_pkg::ADDR_IRQ_STAT:
            avs_readdata[IRQ_W_L-1:0] <= irq_stat_q;
          cmch_pkg::ADDR_IRQ_EN:
            avs_readdata[IRQ_W_L-1:0] <= irq_en_q;
          cmch_pkg::ADDR_CORE_STAT:
            avs_readdata[1:0] <= {enable_written_q, synced_q};
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_ctl1_write_gate: assert property (
    (wr_fire && avs_address == cmch_pkg::ADDR_CTL1 && !in_init)
      |=> $stable(ctl1_q[6:2])) else $error("ctl1 written outside init");
  a_enable_once: assert property (
    (enable_written_q && !special_mode_i)
      |=> $stable(ctl1_q[cmch_pkg::CTL1_ENABLE]))
    else $error("enable rewritten");
  a_loop_pin_high: assert property (
    loop_on |-> (bus_transmit_pin_o && core_rx_bit_o == core_tx_bit_i))
    else $error("loopback path wrong");
  a_listen_silent: assert property (
    listen_on |-> (!core_ack_drive_en_o && !core_err_frame_en_o
                   && core_err_cnt_freeze_o && !core_tx_start_en_o))
    else $error("listen mode drives bus");
  a_bit3_zero: assert property (
    ctl1_q[3] == 1'b0) else $error("bit three set");
  a_sleep_idle: assert property (
    $rose(sleep_ack) |-> $past(bus_idle)) else $error("sleep not idle");
  a_wake_clears: assert property (
    wake_hit |=> !sleep_ack && !sleep_req) else $error("wake ignored");
  a_init_ack: assert property (
    $rose(init_req) |=> init_ack) else $error("init ack late");
  a_irq_sticky: assert property (
    core_tx_done_i && core_rx_done_i |=> irq_stat_q[1:0] == 2'b11)
    else $error("interrupt lost");

  c_init_entry: cover property ($rose(in_init));
  c_sleep_wake: cover property (sleeping ##[1:50] wake_hit);
  c_loop_frame: cover property (loop_on && core_rx_done_i);

endmodule

// [rtl/cmch_pkg.sv]
// package: register map, field positions, reset values and timing counts
package cmch_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTL0      = 8'h00;
  localparam logic [7:0] ADDR_CTL1      = 8'h04;
  localparam logic [7:0] ADDR_BTR_A     = 8'h08;
  localparam logic [7:0] ADDR_BTR_B     = 8'h0C;
  localparam logic [7:0] ADDR_ACC_CTL   = 8'h10;
  localparam logic [7:0] ADDR_ACC_CODE  = 8'h14;
  localparam logic [7:0] ADDR_ACC_MASK  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h24;
  localparam logic [7:0] ADDR_CORE_STAT = 8'h28;

  // ---------------------------------------------------------------
  // mode_control_handshake fields
  // ---------------------------------------------------------------
  localparam int CTL1_ENABLE = 7;
  localparam int CTL1_CLKSEL = 6;
  localparam int CTL1_LOOP   = 5;
  localparam int CTL1_LISTEN = 4;
  localparam int CTL1_WFILT  = 2;
  localparam int CTL1_SLEEP_ACK_FLAG  = 1;
  localparam int CTL1_INIT_ACK_FLAG = 0;
  localparam logic [7:0] CTL1_WR_MASK = 8'hF4;
  localparam logic [7:0] CTL1_RESET   = 8'h00;

  // control register 0 fields (requests and wake enable)
  localparam int CTL0_INIT_REQUEST = 0;
  localparam int CTL0_SLEEP_REQUEST  = 1;
  localparam int CTL0_WAKE   = 2;
  localparam logic [7:0] CTL0_RESET = 8'h01;

  // interrupt status bits
  localparam int IRQ_TX   = 0;
  localparam int IRQ_RX   = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_W    = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 100;
  localparam int WAKE_PULSE_MIN_NS   = 2000;
  localparam int WAKE_PULSE_CYCLES   =
    (WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESYNC_RECESSIVE    = 11;

endpackage

// [rtl/cmch_core_if.sv]
// interface: wake detection hooks between mode control and bus filter
`timescale 1ns/1ns
interface cmch_core_if;
  logic bus_rx;
  logic wake_req;
  logic wake_filt;
  logic sleeping;

  modport ctl  (input  wake_req, output bus_rx, output wake_filt,
                output sleeping);
  modport filt (output wake_req, input  bus_rx, input  wake_filt,
                input  sleeping);
endinterface

// [rtl/cmch_wake_filter.sv]
// module: wake-up detector with optional minimum pulse filter
`timescale 1ns/1ns
module cmch_wake_filter #(
  parameter int PULSE_CYCLES = cmch_pkg::WAKE_PULSE_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  cmch_core_if.filt core
);

  // the counter is 16 bits wide and saturates
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) begin : g_bad_pulse
    $error("pulse count out of range");
  end

  logic [15:0] cnt_q;

  // ---------------------------------------------------------------
  // dominant-level counter, restarted on every recessive bit
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 16'h0000;
    end else if (!core.sleeping || core.bus_rx) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign core.wake_req = core.sleeping && !core.bus_rx &&
    (!core.wake_filt || (cnt_q >= 16'(PULSE_CYCLES - 1)));

endmodule

// [bench/cmch_bus_node.sv]
// far bus side model: one remote node that can pull the wire dominant
`timescale 1ns/1ns
module cmch_bus_node (
  input  wire logic bus_transmit_pin_i,
  output logic      bus_receive_pin_o
);
  logic dom_q = 1'h0;
  // wired-and bus: a dominant low from either side beats the pull-up
  assign bus_receive_pin_o = bus_transmit_pin_i & ~dom_q;
  task automatic drive(input logic v);
    dom_q <= v;
  endtask
endmodule

// [bench/tb.sv]
// testbench: registers, mode outputs, sleep and wake of the mode block
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] C0 = cmch_pkg::ADDR_CTL0;
  localparam logic [7:0] C1 = cmch_pkg::ADDR_CTL1;
  localparam logic [7:0] BT = cmch_pkg::ADDR_BTR_A;
  localparam logic [7:0] IS = cmch_pkg::ADDR_IRQ_STAT;
  localparam logic [7:0] IC = cmch_pkg::ADDR_IRQ_CLR;
  localparam logic [7:0] IE = cmch_pkg::ADDR_IRQ_EN;
  typedef struct packed {
    logic       wr;
    logic [7:0] a;
    logic [7:0] d;
  } cmch_row_t;
  logic        ref_clk_i     = 1'h0;
  logic        sys_rst_i     = 1'h1;
  logic [7:0]  avs_address   = 8'h00;
  logic        avs_read      = 1'h0;
  logic        avs_write     = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, avs_response_err;
  logic        special_mode  = 1'h0;
  logic        tx_bit        = 1'h1;
  logic        rx_busy       = 1'h0;
  logic        tx_busy       = 1'h0;
  logic        tx_empty      = 1'h1;
  logic        bus_off       = 1'h0;
  logic        tx_done       = 1'h0;
  logic        rx_done       = 1'h0;
  logic        tick          = 1'h0;
  logic        rx_pin, tx_pin, rx_bit, en, clk_sel, abort, synced;
  logic        ack_ign, ack_drv, err_frm, frz, tx_st, irq;
  int          errors        = 0;
  int          checks        = 0;
  // write rows carry data, read rows the expected byte
  cmch_row_t   rows [15]     = '{
    '{1'h0, C0, 8'h01}, '{1'h0, C1, 8'h01}, '{1'h1, C1, 8'hFF},
    '{1'h0, C1, 8'hF5}, '{1'h1, C1, 8'h74}, '{1'h0, C1, 8'hF5},
    '{1'h1, BT, 8'h5A}, '{1'h0, BT, 8'h5A}, '{1'h1, C0, 8'h00},
    '{1'h0, C1, 8'hF4}, '{1'h1, C1, 8'h00}, '{1'h0, C1, 8'hF4},
    '{1'h1, BT, 8'h00}, '{1'h0, BT, 8'h5A}, '{1'h0, 8'h40, 8'h00}};

  always #50 ref_clk_i = ~ref_clk_i;

  cmch_top #(.WAKE_CYCLES(3)) i_dut (
    .ref_clk_i             (ref_clk_i),
    .sys_rst_i             (sys_rst_i),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .avs_response_err      (avs_response_err),
    .special_mode_i        (special_mode),
    .bus_receive_pin_i     (rx_pin),
    .bus_transmit_pin_o    (tx_pin),
    .core_tx_bit_i         (tx_bit),
    .core_tx_busy_i        (tx_busy),
    .core_rx_busy_i        (rx_busy),
    .core_tx_empty_i       (tx_empty),
    .core_tx_done_i        (tx_done),
    .core_rx_done_i        (rx_done),
    .core_bit_tick_i       (tick),
    .core_bus_off_i        (bus_off),
    .core_rx_bit_o         (rx_bit),
    .core_enable_o         (en),
    .core_clk_sel_o        (clk_sel),
    .core_abort_o          (abort),
    .core_synced_o         (synced),
    .core_ack_ignore_o     (ack_ign),
    .core_ack_drive_en_o   (ack_drv),
    .core_err_frame_en_o   (err_frm),
    .core_err_cnt_freeze_o (frz),
    .core_tx_start_en_o    (tx_st),
    .irq_o                 (irq)
  );
  cmch_bus_node i_node (
    .bus_transmit_pin_i (tx_pin),
    .bus_receive_pin_o  (rx_pin)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // request held until waitrequest is sampled low; one idle edge after
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    q = avs_readdata[7:0];
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge ref_clk_i);
    if (n >= 20) begin
      errors++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'h0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic dom(input int n);
    i_node.drive(1'h1);
    cyc(n);
    i_node.drive(1'h0);
    cyc(4);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    cmch_row_t  r;
    logic [7:0] q;
    cyc(20);
    sys_rst_i <= 1'h0;
    cyc(2);
    foreach (rows[i]) begin
      r = rows[i];
      bus(r.wr, r.a, r.d, q);
      if (!r.wr) chk(q, r.d);
    end
    chk(avs_response_err, 1'h1);
    // loopback with listen-only: pin ignored, transmit held recessive
    i_node.drive(1'h1);
    cyc(4);
    chk({tx_pin, rx_bit}, 2'h3);
    tx_bit <= 1'h0;
    i_node.drive(1'h0);
    cyc(4);
    chk({tx_pin, rx_bit}, 2'h2);
    tx_bit <= 1'h1;
    chk({en, clk_sel, ack_ign}, 3'h7);
    chk({ack_drv, err_frm, frz, tx_st}, 4'h2);
    wr(IE, 8'h04);
    tx_done <= 1'h1;
    rx_done <= 1'h1;
    cyc(1);
    tx_done <= 1'h0;
    rx_done <= 1'h0;
    rd(IS, 8'h03);
    chk(irq, 1'h0);
    wr(IE, 8'h07);
    cyc(2);
    chk(irq, 1'h1);
    wr(IC, 8'h03);
    cyc(2);
    chk(irq, 1'h0);
    // special mode rewrites enable; normal mode, then resync count
    special_mode <= 1'h1;
    wr(C0, 8'h01);
    wr(C1, 8'h84);
    rd(C1, 8'h85);
    chk({abort, tx_pin}, 2'h3);
    wr(C0, 8'h00);
    cyc(2);
    chk({en, clk_sel, ack_ign, abort}, 4'h8);
    chk({ack_drv, err_frm, frz, tx_st}, 4'hD);
    tx_bit <= 1'h0;
    cyc(3);
    chk(tx_pin, 1'h0);
    tx_bit <= 1'h1;
    cyc(3);
    // bus-off holds the recessive count at zero
    // bus-off blocks resync
    bus_off <= 1'h1;
    repeat (2) begin
      tick <= 1'h1;
      cyc(1);
      tick <= 1'h0;
      cyc(1);
    end
    bus_off <= 1'h0;
    repeat (11) begin
      chk(synced, 1'h0);
      tick <= 1'h1;
      cyc(1);
      tick <= 1'h0;
      cyc(1);
    end
    cyc(2);
    chk(synced, 1'h1);
    // sleep waits for idle; short pulse filtered, long one wakes
    rx_busy  <= 1'h1;
    tx_busy  <= 1'h1;
    tx_empty <= 1'h0;
    wr(C0, 8'h06);
    cyc(3);
    rd(C1, 8'h84);
    rx_busy <= 1'h0;
    cyc(3);
    rd(C1, 8'h84);
    tx_busy <= 1'h0;
    cyc(3);
    rd(C1, 8'h84);
    tx_empty <= 1'h1;
    cyc(3);
    rd(C1, 8'h86);
    dom(2);
    rd(C1, 8'h86);
    dom(6);
    rd(C1, 8'h84);
    rd(IS, 8'h04);
    chk(irq, 1'h1);
    wr(IC, 8'h04);
    wr(C0, 8'h02);
    cyc(3);
    rd(C1, 8'h86);
    dom(6);
    rd(C1, 8'h86);
    wr(C0, 8'h01);
    wr(C1, 8'h00);
    cyc(2);
    chk({en, tx_pin}, 2'h1);
    conclude();
  end
endmodule
